/* File: inc/mfd_map.svh */
// Operation
// [R1] Only enabled axes are compared, and an axis is a candidate when its magnitude is above the threshold.
// [R2] A sample whose magnitude is below the threshold never makes a candidate on any axis.
// [R3] With OR combination the condition holds when any enabled axis is a candidate.
// [R4] With AND combination the condition holds only when all enabled axes are candidates together.
// [R5] The event is raised only after the condition has held for more than the debounce count.
// [R6] With latching on, the event interrupt and status stay held until software reads the status.
// [R7] With latching off, the interrupt follows the event and the status shows the latest event.
// [R8] Factory default sets for motion and for freefall can be chosen instead of the user values.
// [R9] New threshold and debounce values take effect only when software applies them.
// [R10] In decrement mode a false sample before the debounce count is reached steps the count down.
// [R11] In clear mode a false sample before the debounce count is reached returns the count to zero.
// [R12] The status reports the triggering axes and the sign of each triggering axis.
// [R13] The debounce count advances once per sample while the condition holds.
`ifndef MFD_MAP_SVH
`define MFD_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define MFD_CTRL_OFF      8'h00
`define MFD_THR_OFF       8'h04
`define MFD_DBNC_OFF      8'h08
`define MFD_APPLY_OFF     8'h0C
`define MFD_EVT_STAT_OFF  8'h10
`define MFD_IRQ_STAT_OFF  8'h14
`define MFD_IRQ_MASK_OFF  8'h18
`define MFD_DBNC_CNT_OFF  8'h1C

// ****************************************************************
// Control fields
// ****************************************************************
`define MFD_CTRL_XEN      0
`define MFD_CTRL_YEN      1
`define MFD_CTRL_ZEN      2
`define MFD_CTRL_AND      3
`define MFD_CTRL_LATCH    4
`define MFD_CTRL_DEC      5
`define MFD_CTRL_DEF_MOT  6
`define MFD_CTRL_DEF_FF   7
`define MFD_CTRL_RST      8'h07

// ****************************************************************
// Status fields and reset values
// ****************************************************************
`define MFD_EVT_NEG_LSB   3
`define MFD_EVT_FLAG      7
`define MFD_IRQ_START     0
`define MFD_IRQ_END       1
`define MFD_IRQ_MASK_RST  2'h0
`define MFD_THR_RST       12'h100
`define MFD_DBNC_RST      8'h04

// ****************************************************************
// Factory default sets
// ****************************************************************
`define MFD_MOT_THR       12'h100
`define MFD_MOT_DBNC      8'h02
`define MFD_FF_THR        12'h080
`define MFD_FF_DBNC       8'h06

`endif

/* File: inc/mfd_pkg.sv */
// ****************************************************************
// Types shared by the detector files
// ****************************************************************
package mfd_pkg;

  // Debounce states, one-hot.
  typedef enum logic [2:0] {
    MFD_IDLE   = 3'b001,
    MFD_COUNT  = 3'b010,
    MFD_ACTIVE = 3'b100
  } mfd_state_e;

endpackage : mfd_pkg

/* File: hw/mfd_axis_cmp.sv */
`timescale 1ns/1ps
// ****************************************************************
// One axis: magnitude against threshold
// ****************************************************************
module mfd_axis_cmp #(
  parameter int DATA_W = 12
) (
  input  wire logic signed [DATA_W-1:0] sample,
  input  wire logic        [DATA_W-1:0] threshold,
  input  wire logic                     enable,
  output wire logic                     hit,
  output wire logic                     neg
);

  // The most negative sample still fits as an unsigned magnitude.
  wire logic [DATA_W-1:0] magnitude;

  // Sign and magnitude of the sample.
  assign neg       = sample[DATA_W-1];
  assign magnitude = neg ? DATA_W'(~sample + 1'b1) : sample;

  // A disabled axis, or a magnitude at or below threshold, never hits.
  assign hit = enable & (magnitude > threshold); // [R1] [R2]

endmodule : mfd_axis_cmp

/* File: hw/mfd_detector.sv */
`timescale 1ns/1ps
`include "mfd_map.svh"
// ****************************************************************
// Motion and freefall event detector with APB registers
// ****************************************************************
module mfd_detector
  import mfd_pkg::*;
#(
  parameter int DATA_W = 12,
  parameter int DBNC_W = 8
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     sample_valid,
  input  wire logic signed [DATA_W-1:0] sample_x,
  input  wire logic signed [DATA_W-1:0] sample_y,
  input  wire logic signed [DATA_W-1:0] sample_z,
  output logic                          evt_int,
  output logic                          irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic        [7:0]        ctrl_r;
  logic        [DATA_W-1:0] thr_stage_r;
  logic        [DBNC_W-1:0] dbnc_stage_r;
  logic        [DATA_W-1:0] thr_act_r;
  logic        [DBNC_W-1:0] dbnc_act_r;
  logic        [1:0]        irq_stat_r;
  logic        [1:0]        irq_mask_r;
  logic        [2:0]        evt_axes_r;
  logic        [2:0]        evt_neg_r;
  logic                     evt_int_r;
  logic                     irq_r;
  logic        [31:0]       prdata_r;
  logic                     pready_r;
  logic                     pslverr_r;
  mfd_state_e               state_r;
  mfd_state_e               state_nxt;
  logic        [DBNC_W-1:0] cnt_r;
  logic        [DBNC_W-1:0] cnt_nxt;

  wire logic signed [DATA_W-1:0] sample_arr [3];
  wire logic        [2:0]        hit;
  wire logic        [2:0]        neg;
  wire logic                     use_mot;
  wire logic                     use_ff;
  wire logic        [DATA_W-1:0] eff_thr;
  wire logic        [DBNC_W-1:0] eff_dbnc;
  wire logic        [2:0]        eff_en;
  wire logic                     eff_and;
  wire logic                     latch_en;
  wire logic                     dec_mode;
  wire logic                     cond_or;
  wire logic                     cond_and;
  wire logic                     cond;
  wire logic                     evt_start;
  wire logic                     evt_end;
  wire logic                     capture;
  wire logic                     setup;
  wire logic                     wr_fire;
  wire logic                     rd_fire;
  wire logic                     mapped;
  wire logic                     status_rd;
  wire logic        [31:0]       rd_mux;
  wire logic        [1:0]        irq_stat_nxt;
  wire logic                     evt_int_nxt;

  // ****************************************************************
  // Address decode helper
  // ****************************************************************
  // True when the bus address selects the given register word.
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr[7:2] == off[7:2]);
  endfunction : reg_hit

  // ****************************************************************
  // APB handshake decode
  // ****************************************************************
  // A setup cycle loads the answer, the following access cycle completes.
  assign setup     = psel & ~penable;
  assign wr_fire   = psel & penable & pready_r & pwrite & ~pslverr_r;
  assign rd_fire   = psel & penable & pready_r & ~pwrite & ~pslverr_r;
  assign status_rd = rd_fire & reg_hit(paddr, `MFD_EVT_STAT_OFF);

  // Only the eight word offsets answer without error.
  assign mapped = reg_hit(paddr, `MFD_CTRL_OFF)     |
                  reg_hit(paddr, `MFD_THR_OFF)      |
                  reg_hit(paddr, `MFD_DBNC_OFF)     |
                  reg_hit(paddr, `MFD_APPLY_OFF)    |
                  reg_hit(paddr, `MFD_EVT_STAT_OFF) |
                  reg_hit(paddr, `MFD_IRQ_STAT_OFF) |
                  reg_hit(paddr, `MFD_IRQ_MASK_OFF) |
                  reg_hit(paddr, `MFD_DBNC_CNT_OFF);

  // ****************************************************************
  // Effective parameter selection
  // ****************************************************************
  // Motion defaults win when both default sets are chosen.
  assign use_mot  = ctrl_r[`MFD_CTRL_DEF_MOT];
  assign use_ff   = ~use_mot & ctrl_r[`MFD_CTRL_DEF_FF];

  // A default set replaces threshold, debounce, axes and combination.
  assign eff_thr  = use_mot ? DATA_W'(`MFD_MOT_THR) :
                    use_ff  ? DATA_W'(`MFD_FF_THR)  : thr_act_r; // [R8]
  assign eff_dbnc = use_mot ? DBNC_W'(`MFD_MOT_DBNC) :
                    use_ff  ? DBNC_W'(`MFD_FF_DBNC)  : dbnc_act_r; // [R8]
  assign eff_en   = (use_mot | use_ff) ? 3'h7 : ctrl_r[`MFD_CTRL_ZEN:`MFD_CTRL_XEN]; // [R8]
  assign eff_and  = use_mot ? 1'b0 : (use_ff ? 1'b1 : ctrl_r[`MFD_CTRL_AND]); // [R8]
  assign latch_en = ctrl_r[`MFD_CTRL_LATCH];
  assign dec_mode = ctrl_r[`MFD_CTRL_DEC];

  // ****************************************************************
  // Per-axis comparison
  // ****************************************************************
  assign sample_arr[0] = sample_x;
  assign sample_arr[1] = sample_y;
  assign sample_arr[2] = sample_z;

  // One comparator per axis.
  generate
    for (genvar i = 0; i < 3; i++) begin : g_axis
      mfd_axis_cmp #(
        .DATA_W    (DATA_W)
      ) u_cmp (
        .sample    (sample_arr[i]),
        .threshold (eff_thr),
        .enable    (eff_en[i]),
        .hit       (hit[i]),
        .neg       (neg[i])
      );
    end
  endgenerate

  // ****************************************************************
  // Axis combination
  // ****************************************************************
  // AND needs every enabled axis and at least one enabled axis.
  assign cond_or  = |hit; // [R3]
  assign cond_and = (&(hit | ~eff_en)) & (|eff_en); // [R4]
  assign cond     = eff_and ? cond_and : cond_or; // [R3] [R4]

  // ****************************************************************
  // Debounce state machine
  // ****************************************************************
  // The counter moves only on a sample strobe.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      MFD_IDLE: begin
        if (sample_valid && cond) begin
          if (cnt_r >= eff_dbnc) begin
            state_nxt = MFD_ACTIVE; // [R5]
          end else begin
            state_nxt = MFD_COUNT;
            cnt_nxt   = DBNC_W'(cnt_r + 1'b1); // [R13]
          end
        end
      end
      MFD_COUNT: begin
        if (sample_valid && cond) begin
          if (cnt_r >= eff_dbnc) begin
            state_nxt = MFD_ACTIVE; // [R5]
          end else begin
            cnt_nxt = DBNC_W'(cnt_r + 1'b1); // [R13]
          end
        end else if (sample_valid) begin
          if (dec_mode) begin
            cnt_nxt = DBNC_W'(cnt_r - 1'b1); // [R10]
            if (cnt_r == DBNC_W'(1)) begin
              state_nxt = MFD_IDLE;
            end
          end else begin
            cnt_nxt   = '0; // [R11]
            state_nxt = MFD_IDLE;
          end
        end
      end
      MFD_ACTIVE: begin
        if (sample_valid && !cond) begin
          state_nxt = MFD_IDLE;
          cnt_nxt   = '0;
        end
      end
      default: begin
        state_nxt = MFD_IDLE;
        cnt_nxt   = '0;
      end
    endcase
  end

  // State and counter registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= MFD_IDLE;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // ****************************************************************
  // Event edges, status capture and event interrupt
  // ****************************************************************
  assign evt_start = (state_r != MFD_ACTIVE) & (state_nxt == MFD_ACTIVE);
  assign evt_end   = (state_r == MFD_ACTIVE) & (state_nxt != MFD_ACTIVE);

  // A held latched status is not overwritten until it has been read.
  assign capture = evt_start & (~latch_en | ~evt_int_r | status_rd); // [R6] [R7]

  // Latched: a new event wins over a read in the same cycle.
  assign evt_int_nxt = latch_en ? (evt_start | (evt_int_r & ~status_rd)) // [R6]
                                : (state_nxt == MFD_ACTIVE); // [R7]

  // Event status and interrupt registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_axes_r <= '0;
      evt_neg_r  <= '0;
      evt_int_r  <= 1'b0;
    end else begin
      if (capture) begin
        evt_axes_r <= hit; // [R12]
        evt_neg_r  <= neg & hit; // [R12]
      end
      evt_int_r <= evt_int_nxt;
    end
  end

  // ****************************************************************
  // Sticky interrupt status
  // ****************************************************************
  // Setting wins over a write-one-to-clear in the same cycle.
  assign irq_stat_nxt = (irq_stat_r & ~((wr_fire & reg_hit(paddr, `MFD_IRQ_STAT_OFF))
                                        ? pwdata[1:0] : 2'h0))
                        | {evt_end, evt_start};

  // Interrupt status and level output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
      irq_r      <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_r      <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Thresholds are staged and reach the detector only on apply.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r       <= `MFD_CTRL_RST;
      thr_stage_r  <= DATA_W'(`MFD_THR_RST);
      dbnc_stage_r <= DBNC_W'(`MFD_DBNC_RST);
      thr_act_r    <= DATA_W'(`MFD_THR_RST);
      dbnc_act_r   <= DBNC_W'(`MFD_DBNC_RST);
      irq_mask_r   <= `MFD_IRQ_MASK_RST;
    end else if (wr_fire) begin
      if (reg_hit(paddr, `MFD_CTRL_OFF)) begin
        ctrl_r <= pwdata[7:0];
      end
      if (reg_hit(paddr, `MFD_THR_OFF)) begin
        thr_stage_r <= pwdata[DATA_W-1:0]; // [R9]
      end
      if (reg_hit(paddr, `MFD_DBNC_OFF)) begin
        dbnc_stage_r <= pwdata[DBNC_W-1:0]; // [R9]
      end
      if (reg_hit(paddr, `MFD_APPLY_OFF) && pwdata[0]) begin
        thr_act_r  <= thr_stage_r; // [R9]
        dbnc_act_r <= dbnc_stage_r; // [R9]
      end
      if (reg_hit(paddr, `MFD_IRQ_MASK_OFF)) begin
        irq_mask_r <= pwdata[1:0];
      end
    end
  end

  // ****************************************************************
  // Read data selection
  // ****************************************************************
  // Unused upper bits read as zero.
  assign rd_mux =
    reg_hit(paddr, `MFD_CTRL_OFF)     ? {24'h0, ctrl_r} :
    reg_hit(paddr, `MFD_THR_OFF)      ? {{(32-DATA_W){1'b0}}, thr_stage_r} :
    reg_hit(paddr, `MFD_DBNC_OFF)     ? {{(32-DBNC_W){1'b0}}, dbnc_stage_r} :
    reg_hit(paddr, `MFD_APPLY_OFF)    ? {{(16-DBNC_W){1'b0}}, dbnc_act_r,
                                         {(16-DATA_W){1'b0}}, thr_act_r} :
    reg_hit(paddr, `MFD_EVT_STAT_OFF) ? {24'h0, evt_int_r, 1'b0, evt_neg_r, evt_axes_r} :
    reg_hit(paddr, `MFD_IRQ_STAT_OFF) ? {30'h0, irq_stat_r} :
    reg_hit(paddr, `MFD_IRQ_MASK_OFF) ? {30'h0, irq_mask_r} :
    reg_hit(paddr, `MFD_DBNC_CNT_OFF) ? {{(29-DBNC_W){1'b0}}, state_r, cnt_r} :
                                        32'h0;

  // ****************************************************************
  // APB answer registers
  // ****************************************************************
  // The answer is loaded in the setup cycle and shown for one access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~mapped;
      if (setup) begin
        prdata_r <= pwrite ? 32'h0 : rd_mux;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign evt_int = evt_int_r;
  assign irq     = irq_r;

endmodule : mfd_detector

/* File: dv/mfd_sample_src.sv */
`timescale 1ns/1ps
// ****************************************************************
// Sample source standing in for the sensor front end
// ****************************************************************
module mfd_sample_src #(
  parameter int DATA_W = 12
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     go,
  input  wire logic        [DATA_W-1:0] x_in,
  input  wire logic        [DATA_W-1:0] y_in,
  input  wire logic        [DATA_W-1:0] z_in,
  output logic                          sample_valid,
  output logic signed [DATA_W-1:0]      sample_x,
  output logic signed [DATA_W-1:0]      sample_y,
  output logic signed [DATA_W-1:0]      sample_z
);
  // A request gives a one-cycle sample; between samples the data lines
  // invert on every cycle, so stale data is never mistaken.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_valid <= 1'b0;
      sample_x     <= '0;
      sample_y     <= '0;
      sample_z     <= '0;
    end else begin
      sample_valid <= go;
      sample_x     <= go ? x_in : ~sample_x;
      sample_y     <= go ? y_in : ~sample_y;
      sample_z     <= go ? z_in : ~sample_z;
    end
  end
endmodule : mfd_sample_src

/* File: dv/mfd_detector_sva.sv */
`timescale 1ns/1ps
// ****************************************************************
// Port checker for the detector
// ****************************************************************
module mfd_detector_sva
  import mfd_pkg::*;
#(
  parameter int DATA_W = 12,
  parameter int DBNC_W = 8
) (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [7:0]               paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic                     sample_valid,
  input wire logic signed [DATA_W-1:0] sample_x,
  input wire logic signed [DATA_W-1:0] sample_y,
  input wire logic signed [DATA_W-1:0] sample_z,
  input wire logic                     evt_int,
  input wire logic                     irq
);
  // Completed accesses: any write, and a read of the event status.
  wire  acc     = psel && penable && pready;
  wire  wr_acc  = acc && pwrite;
  wire  rd_stat = acc && !pwrite && (paddr[7:2] == 6'h04);
  logic evt_q;
  wire  evt_chg = evt_int != evt_q;

  // Delayed event output, used to spot the edge that sets a status bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) evt_q <= 1'b0;
    else evt_q <= evt_int;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  a_write_no_data: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on a write");
  a_evt_rise_sample: assert property ($rose(evt_int) |-> $past(sample_valid))
    else $error("event rose without a sample");
  a_evt_fall_cause: assert property ($fell(evt_int) |->
    $past(sample_valid) || $past(rd_stat) || $past(wr_acc))
    else $error("event fell without a cause");
  a_evt_quiet_hold: assert property (!sample_valid && !rd_stat && !wr_acc |=>
    $stable(evt_int))
    else $error("event changed while quiet");
  a_irq_rise_cause: assert property ($rose(irq) |->
    $past(evt_chg) || $past(wr_acc, 2) || $past(sample_valid, 2))
    else $error("irq rose without a cause");
  a_irq_fall_write: assert property ($fell(irq) |-> $past(wr_acc, 2))
    else $error("irq fell without a write");

  c_evt_rise: cover property ($rose(evt_int));
  c_irq_rise: cover property ($rose(irq));
  c_bus_error: cover property (pslverr);
  c_stat_clear: cover property (rd_stat ##1 $fell(evt_int));
endmodule : mfd_detector_sva

bind mfd_detector mfd_detector_sva #(.DATA_W(DATA_W), .DBNC_W(DBNC_W)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sample_valid(sample_valid), .sample_x(sample_x), .sample_y(sample_y),
  .sample_z(sample_z), .evt_int(evt_int), .irq(irq)
);

/* File: dv/mfd_detector_tb.sv */
`timescale 1ns/1ps
`include "mfd_map.svh"
// ****************************************************************
// Testbench for the motion and freefall detector
// ****************************************************************
module mfd_detector_tb
  import mfd_pkg::*;
;
  logic               pclk = 1'b0, presetn = 1'b0, go = 1'b0;
  logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready, pslverr, evt_int, irq, sv;
  logic [11:0]        sx = 12'h000, sy = 12'h000, sz = 12'h000;
  logic signed [11:0] dx, dy, dz;
  int                 error_cnt = 0;
  int                 compares = 0;

  // Clock at 25 MHz.
  always #20 pclk = ~pclk;

  mfd_detector #(.DATA_W(12), .DBNC_W(8)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sv), .sample_x(dx), .sample_y(dy), .sample_z(dz),
    .evt_int(evt_int), .irq(irq));

  mfd_sample_src #(.DATA_W(12)) u_src (
    .pclk(pclk), .presetn(presetn), .go(go), .x_in(sx), .y_in(sy), .z_in(sz),
    .sample_valid(sv), .sample_x(dx), .sample_y(dy), .sample_z(dz));

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One APB transfer, held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      error_cnt++;
      give_verdict();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(name, exp, r);
  endtask : rd_chk

  // Sends one sample and waits until its effect on the outputs has landed.
  task automatic smp(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
    @(posedge pclk);
    go <= 1'b1;
    sx <= x;
    sy <= y;
    sz <= z;
    @(posedge pclk);
    go <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
  endtask : smp

  task automatic evt(input logic exp);
    chk("evt_int", {31'h0, exp}, {31'h0, evt_int});
  endtask : evt

  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge pclk);
    #1;
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask : irq_chk

  // Main sequence: reset, registers, detection modes, latch, defaults.
  initial begin
    logic [31:0] r;
    logic        e;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("ctrl", `MFD_CTRL_OFF, 32'h07);
    rd_chk("apply", `MFD_APPLY_OFF, 32'h0004_0100);
    rd_chk("mask", `MFD_IRQ_MASK_OFF, 32'h0);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk("unmapped data", 32'h0, r);
    chk("unmapped err", 32'h1, {31'h0, e});
    wr(`MFD_THR_OFF, 32'h050);
    wr(`MFD_DBNC_OFF, 32'h02);
    rd_chk("apply", `MFD_APPLY_OFF, 32'h0004_0100);
    wr(`MFD_APPLY_OFF, 32'h1);
    rd_chk("apply", `MFD_APPLY_OFF, 32'h0002_0050);
    wr(`MFD_CTRL_OFF, 32'h01);
    smp(12'h050, 12'h7FF, 12'h7FF);
    rd_chk("count", `MFD_DBNC_CNT_OFF, 32'h100);
    repeat (2) smp(12'h051, 12'h000, 12'h000);
    rd_chk("count", `MFD_DBNC_CNT_OFF, 32'h202);
    evt(1'b0);
    smp(12'h051, 12'h000, 12'h000);
    evt(1'b1);
    rd_chk("status", `MFD_EVT_STAT_OFF, 32'h81);
    smp(12'h000, 12'h000, 12'h000);
    evt(1'b0);
    repeat (2) smp(12'h051, 12'h000, 12'h000);
    smp(12'h000, 12'h000, 12'h000);
    rd_chk("count", `MFD_DBNC_CNT_OFF, 32'h100);
    wr(`MFD_CTRL_OFF, 32'h21);
    repeat (2) smp(12'h051, 12'h000, 12'h000);
    smp(12'h000, 12'h000, 12'h000);
    rd_chk("count", `MFD_DBNC_CNT_OFF, 32'h201);
    smp(12'h000, 12'h000, 12'h000);
    rd_chk("count", `MFD_DBNC_CNT_OFF, 32'h100);
    wr(`MFD_CTRL_OFF, 32'h03);
    smp(12'hFA0, 12'h010, 12'h000);
    rd_chk("count", `MFD_DBNC_CNT_OFF, 32'h201);
    wr(`MFD_CTRL_OFF, 32'h0B);
    smp(12'hFA0, 12'h010, 12'h000);
    rd_chk("count", `MFD_DBNC_CNT_OFF, 32'h100);
    repeat (3) smp(12'hFA0, 12'h060, 12'h000);
    evt(1'b1);
    rd_chk("status", `MFD_EVT_STAT_OFF, 32'h8B);
    smp(12'h000, 12'h000, 12'h000);
    wr(`MFD_CTRL_OFF, 32'h13);
    wr(`MFD_IRQ_MASK_OFF, 32'h1);
    wr(`MFD_IRQ_STAT_OFF, 32'h3);
    repeat (3) smp(12'h100, 12'h000, 12'h000);
    smp(12'h000, 12'h000, 12'h000);
    evt(1'b1);
    chk("irq", 32'h1, {31'h0, irq});
    rd_chk("status", `MFD_EVT_STAT_OFF, 32'h81);
    @(posedge pclk);
    #1;
    evt(1'b0);
    rd_chk("irq stat", `MFD_IRQ_STAT_OFF, 32'h3);
    wr(`MFD_IRQ_MASK_OFF, 32'h0);
    irq_chk(1'b0);
    wr(`MFD_IRQ_MASK_OFF, 32'h1);
    irq_chk(1'b1);
    wr(`MFD_IRQ_STAT_OFF, 32'h3);
    irq_chk(1'b0);
    wr(`MFD_CTRL_OFF, 32'h40);
    repeat (2) smp(12'h000, 12'h000, 12'h101);
    evt(1'b0);
    smp(12'h000, 12'h000, 12'h101);
    evt(1'b1);
    smp(12'h000, 12'h000, 12'h000);
    wr(`MFD_CTRL_OFF, 32'h80);
    repeat (6) smp(12'h081, 12'h081, 12'h081);
    evt(1'b0);
    smp(12'h081, 12'h081, 12'h081);
    evt(1'b1);
    give_verdict();
  end
endmodule : mfd_detector_tb
